// ===== hw/pps_pkg.sv
// Constants shared by the power save control block
package pps_pkg;
  localparam int unsigned WORD_BITS       = 19;
  localparam int unsigned REF_BITS        = 14;
  localparam int unsigned SWAL_BITS       = 7;
  localparam int unsigned PROG_BITS       = 11;
  // Field positions in the shifted word, bit 0 is the first bit in (target select)
  localparam int unsigned POS_SELECT      = 0;
  localparam int unsigned POS_REF_LSB     = 1;
  localparam int unsigned POS_PRESCALE    = 15;
  localparam int unsigned POS_PHASE_POL   = 16;
  localparam int unsigned POS_MON_SEL     = 17;
  localparam int unsigned POS_PUMP_CUR    = 18;
  localparam int unsigned POS_SWAL_LSB    = 1;
  localparam int unsigned POS_PROG_LSB    = 8;
  // Reset values of the latched settings
  localparam logic [13:0] REF_RESET       = 14'h0003;
  localparam logic [6:0]  SWAL_RESET      = 7'h00;
  localparam logic [10:0] PROG_RESET      = 11'h003;
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SAVE_LOW_MIN_NS  = 1000;
  localparam int unsigned SAVE_LOW_MIN_CYC = (SAVE_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SOFT_START_NS   = 2000;
  localparam int unsigned SOFT_START_CYC  = SOFT_START_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W          = 9;
  typedef enum logic [1:0] {PPS_SAVE, PPS_SOFT, PPS_RUN} pps_mode_t;
endpackage

// ===== hw/pps_sync.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module pps_sync (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== hw/pps_ctrl.sv
// Power save control with serial load of divider settings
// How it works
// - A high power_save_n runs the synthesizer and a low one puts it in power saving.
// - In power saving the charge pump output enable is released so the pin floats.
// - In power saving lock_detect_out is forced high to report lock.
// - When power_save_n rises the block leaves power saving and runs normally.
// - After leaving power saving the pump drive is clamped for a soft start window.
// - One data bit is shifted in on each rising edge of the serial clock.
// - A rising load_enable latches the word to the reference or main divider by target_select_bit.
`timescale 1ns/1ps
`default_nettype none
module pps_ctrl (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        power_save_n,
  input  wire logic        ser_data,
  input  wire logic        ser_clk,
  input  wire logic        load_enable,
  input  wire logic        pd_up,
  input  wire logic        pd_down,
  input  wire logic        pll_locked,
  output logic             pump_out,
  output logic             pump_oe_n,
  output logic             pump_clamp,
  output logic             lock_detect_out,
  output logic             power_saving,
  output logic [13:0]      ref_div,
  output logic [6:0]       swal_div,
  output logic [10:0]      prog_div,
  output logic             prescale_sel,
  output logic             phase_pol,
  output logic             mon_sel,
  output logic             pump_cur
);
  // Synchronised pin levels
  logic                          save_n_s;
  logic                          data_s;
  logic                          sclk_s;
  logic                          load_s;
  // Previous levels for the edge detectors
  logic                          sclk_prev_q;
  logic                          load_prev_q;
  // Serial word and mode state
  logic [pps_pkg::WORD_BITS-1:0] shift_q;
  pps_pkg::pps_mode_t            mode_q;
  pps_pkg::pps_mode_t            mode_d;
  logic [pps_pkg::TICK_W-1:0]    tick_q;
  logic [pps_pkg::TICK_W-1:0]    tick_d;
  // Named decode wires
  wire                           sclk_rise;
  wire                           load_rise;
  wire                           to_ref;
  wire                           to_main;
  wire                           soft_done;
  wire                           save_d;
  wire                           clamp_d;
  wire                           err_d;
  wire                           level_d;

  // Power save pin
  pps_sync u_save (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (power_save_n),
    .sync_out (save_n_s)
  );

  // Serial data pin, same depth as the serial clock so each bit lines up with its edge
  pps_sync u_data (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (ser_data),
    .sync_out (data_s)
  );

  // Serial clock pin
  pps_sync u_sclk (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (ser_clk),
    .sync_out (sclk_s)
  );

  // Load pin
  pps_sync u_load (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (load_enable),
    .sync_out (load_s)
  );

  // Edge detection; idle low pins match the reset value, so no false edge after reset
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign load_rise = load_s & ~load_prev_q;

  assign to_ref    = load_rise & shift_q[pps_pkg::POS_SELECT];
  assign to_main   = load_rise & ~shift_q[pps_pkg::POS_SELECT];

  // Previous pin levels
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
      load_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      load_prev_q <= load_s;
    end
  end

  // shift on rise
  // Not gated by load_enable: keeping it low while shifting is the controller's duty
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      shift_q <= '0;
    else if (sclk_rise)
      shift_q <= {data_s, shift_q[pps_pkg::WORD_BITS-1:1]};
  end

  // no power-save term here, so settings survive power saving
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_div      <= pps_pkg::REF_RESET;
      prescale_sel <= 1'b0;
      phase_pol    <= 1'b0;
      mon_sel      <= 1'b0;
      pump_cur     <= 1'b0;
    end else if (to_ref) begin
      ref_div      <= shift_q[pps_pkg::POS_REF_LSB +: pps_pkg::REF_BITS];
      prescale_sel <= shift_q[pps_pkg::POS_PRESCALE];
      phase_pol    <= shift_q[pps_pkg::POS_PHASE_POL];
      mon_sel      <= shift_q[pps_pkg::POS_MON_SEL];
      pump_cur     <= shift_q[pps_pkg::POS_PUMP_CUR];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      swal_div <= pps_pkg::SWAL_RESET;
      prog_div <= pps_pkg::PROG_RESET;
    end else if (to_main) begin
      swal_div <= shift_q[pps_pkg::POS_SWAL_LSB +: pps_pkg::SWAL_BITS];
      prog_div <= shift_q[pps_pkg::POS_PROG_LSB +: pps_pkg::PROG_BITS];
    end
  end

  // Last count of the soft start window
  assign soft_done = (tick_q == pps_pkg::TICK_W'(pps_pkg::SOFT_START_CYC - 1));

  // Mode sequencing: save, then a clamped soft start, then run
  always_comb begin
    mode_d = mode_q;
    tick_d = tick_q;
    case (mode_q)
      pps_pkg::PPS_SAVE: begin
        if (save_n_s) begin
          mode_d = pps_pkg::PPS_SOFT;
          tick_d = '0;
        end
      end
      pps_pkg::PPS_SOFT: begin
        if (!save_n_s)
          mode_d = pps_pkg::PPS_SAVE;
        else if (soft_done)
          mode_d = pps_pkg::PPS_RUN;
        else
          tick_d = tick_q + 1'b1;
      end
      pps_pkg::PPS_RUN: begin
        if (!save_n_s)
          mode_d = pps_pkg::PPS_SAVE;
      end
      default: mode_d = pps_pkg::PPS_SAVE;
    endcase
  end

  // Reset lands in power saving, matching the power-on low level the controller must give
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= pps_pkg::PPS_SAVE;
      tick_q <= '0;
    end else begin
      mode_q <= mode_d;
      tick_q <= tick_d;
    end
  end

  // Decode from the next state so the outputs switch on the same edge as the mode
  assign save_d  = (mode_d == pps_pkg::PPS_SAVE);
  assign clamp_d = (mode_d == pps_pkg::PPS_SOFT);
  // Pump drives only on a single-sided error; the current limit itself sits in the pump stage
  assign err_d   = pd_up ^ pd_down;
  assign level_d = phase_pol ? pd_up : pd_down;

  // Power saving flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_saving <= 1'b1;
    end else begin
      power_saving <= save_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pump_oe_n <= 1'b1;
    end else begin
      pump_oe_n <= save_d | ~err_d;
    end
  end

  // Pump level, harmless while the enable is released
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pump_out <= 1'b0;
    end else begin
      pump_out <= level_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pump_clamp <= 1'b0;
    end else begin
      pump_clamp <= clamp_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_detect_out <= 1'b1;
    end else begin
      lock_detect_out <= save_d | pll_locked;
    end
  end
endmodule
`default_nettype wire

// ===== verification/pps_host.sv
// Host controller model for the serial load and power save pins
`timescale 1ns/1ps
`default_nettype none
module pps_host (
  output logic power_save_n,
  output logic ser_data,
  output logic ser_clk,
  output logic load_enable
);
  // power save held low from power-on
  initial begin
    power_save_n = 1'b0;
    ser_data     = 1'b0;
    ser_clk      = 1'b0;
    load_enable  = 1'b0;
  end
  task automatic drive_save_n(input logic v);
    power_save_n = v;
  endtask
  // load low while shifting, bit 0 first
  task automatic load_word(input logic [18:0] w);
    for (int i = 0; i < 19; i++) begin
      ser_data = w[i];
      #40 ser_clk = 1'b1;
      #40 ser_clk = 1'b0;
    end
    ser_data = ~w[18]; // Released data shows no stale bit
    #40 load_enable = 1'b1;
    #100 load_enable = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verification/pps_ctrl_chk.sv
// Checker of the power save control outputs
`timescale 1ns/1ps
`default_nettype none
module pps_ctrl_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic power_save_n,
  input wire logic pll_locked,
  input wire logic pump_oe_n,
  input wire logic pump_clamp,
  input wire logic lock_detect_out,
  input wire logic power_saving
);
  logic [8:0] clamp_len_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Counts clamp cycles, avoids a long repetition
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clamp_len_q <= 9'h000;
    end else begin
      clamp_len_q <= pump_clamp ? clamp_len_q + 9'h001 : 9'h000;
    end
  end
  chk_enter_save: assert property ($fell(power_save_n) |-> ##[1:3] power_saving)
    else $error("power saving not entered");
  chk_leave_save: assert property (power_save_n [*4] |-> !power_saving)
    else $error("power saving not left");
  chk_pump_float: assert property (power_saving |-> pump_oe_n)
    else $error("pump driven while saving");
  chk_lock_high: assert property (power_saving |-> lock_detect_out)
    else $error("lock low while saving");
  chk_lock_follow: assert property (!power_saving && !$past(power_saving) |-> lock_detect_out == $past(pll_locked))
    else $error("lock output wrong in normal mode");
  chk_clamp_start: assert property ($fell(power_saving) |-> pump_clamp)
    else $error("no clamp on leaving saving");
  chk_clamp_len: assert property ($fell(pump_clamp) && !power_saving |-> clamp_len_q == pps_pkg::SOFT_START_CYC)
    else $error("clamp window length wrong");
  chk_clamp_bound: assert property (pump_clamp |-> clamp_len_q < pps_pkg::SOFT_START_CYC)
    else $error("clamp window too long");
  cov_leave: cover property ($fell(power_saving));
  cov_clamp_end: cover property ($fell(pump_clamp));
  cov_enter: cover property ($rose(power_saving));
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Testbench for the power save control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, rst_n, power_save_n, ser_data, ser_clk, load_enable, pd_up, pd_down, pll_locked;
  logic pump_out, pump_oe_n, pump_clamp, lock_detect_out, power_saving, prescale_sel, phase_pol, mon_sel, pump_cur;
  logic [13:0] ref_div;
  logic [6:0]  swal_div;
  logic [10:0] prog_div;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  wire  [35:0] cfg = {ref_div, swal_div, prog_div, pump_cur, mon_sel, phase_pol, prescale_sel};
  typedef struct {logic [18:0] w; logic [35:0] e;} pps_row_t;
  // Word beside the whole latched state it should leave
  pps_row_t rows [4] = '{'{19'h6b579, {14'h1abc, 7'h00, 11'h003, 4'hd}}, '{19'h2a3aa, {14'h1abc, 7'h55, 11'h2a3, 4'hd}},
                         '{19'h07fff, {14'h3fff, 7'h55, 11'h2a3, 4'h0}}, '{19'h7fffe, {14'h3fff, 7'h7f, 11'h7ff, 4'h0}}};
  pps_host host (.power_save_n(power_save_n), .ser_data(ser_data), .ser_clk(ser_clk), .load_enable(load_enable));
  pps_ctrl dut (.clock(clock), .rst_n(rst_n), .power_save_n(power_save_n), .ser_data(ser_data), .ser_clk(ser_clk),
    .load_enable(load_enable), .pd_up(pd_up), .pd_down(pd_down), .pll_locked(pll_locked), .pump_out(pump_out),
    .pump_oe_n(pump_oe_n), .pump_clamp(pump_clamp), .lock_detect_out(lock_detect_out), .power_saving(power_saving),
    .ref_div(ref_div), .swal_div(swal_div), .prog_div(prog_div), .prescale_sel(prescale_sel), .phase_pol(phase_pol),
    .mon_sel(mon_sel), .pump_cur(pump_cur));
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Cuts a hang short well past the expected run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    pd_up = 1'b1;
    pd_down = 1'b0;
    pll_locked = 1'b0;
    tick(8);
    chk("reset", {14'h0003, 7'h00, 11'h003, 4'h0, 3'h7}, {cfg, power_saving, pump_oe_n, lock_detect_out});
    rst_n = 1'b1;
    tick(120);
    chk("saving", 3'h7, {power_saving, pump_oe_n, lock_detect_out});
    host.drive_save_n(1'b1);
    tick(5);
    chk("leave", 2'h1, {power_saving, pump_clamp});
    pll_locked = 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.load_word(rows[i].w);
      tick(10);
      chk("cfg", rows[i].e, cfg);
    end
    // Settings must survive a save period with lock reported
    pll_locked = 1'b0;
    host.drive_save_n(1'b0);
    tick(5);
    chk("retain", {rows[3].e, 3'h7}, {cfg, power_saving, pump_oe_n, lock_detect_out});
    host.drive_save_n(1'b1);
    pd_up = 1'b0;
    pd_down = 1'b1;
    tick(5);
    chk("resume", 4'h2, {power_saving, pump_oe_n, pump_out, lock_detect_out});
    tick(250);
    give_verdict();
  end
endmodule
bind pps_ctrl pps_ctrl_chk u_chk (.clock(clock), .rst_n(rst_n), .power_save_n(power_save_n), .pll_locked(pll_locked),
  .pump_oe_n(pump_oe_n), .pump_clamp(pump_clamp), .lock_detect_out(lock_detect_out), .power_saving(power_saving));
`default_nettype wire
